// file: hw/leak_monitor_pkg.sv
// Constants, register map and state types of the leak and break monitor
package leak_monitor_pkg;

    // Clock and timing in their own units
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned FIRST_CHECK_S = 2;
    localparam longint unsigned CHECK_PERIOD_S = 7;
    localparam longint unsigned CHECK_PULSE_MS = 200;
    localparam longint unsigned DETECT_LIMIT_S = 10;
    localparam longint unsigned AC_TONE_CHZ = 375;
    localparam longint unsigned FLASH_HZ = 1;

    // Cycle counts; divided times round down
    localparam longint unsigned FIRST_CHECK_CYC = CLK_HZ * FIRST_CHECK_S;
    localparam longint unsigned CHECK_PERIOD_CYC = CLK_HZ * CHECK_PERIOD_S;
    localparam longint unsigned CHECK_PULSE_CYC = (CLK_HZ * CHECK_PULSE_MS) / 1000;
    localparam longint unsigned DETECT_LIMIT_CYC = CLK_HZ * DETECT_LIMIT_S;
    localparam longint unsigned AC_HALF_CYC = (CLK_HZ * 100) / (2 * AC_TONE_CHZ);
    localparam longint unsigned FLASH_HALF_CYC = CLK_HZ / (2 * FLASH_HZ);

    // Upper limits of the four detection ranges, in kilohm
    localparam int unsigned RANGE0_KOHM = 250;
    localparam int unsigned RANGE1_KOHM = 600;
    localparam int unsigned RANGE2_KOHM = 5000;
    localparam int unsigned RANGE3_KOHM = 50000;
    localparam logic [1:0] RANGE_LARGEST = 2'h3;

    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CHECKS = 4'h8;
    localparam logic [3:0] REG_LEVEL = 4'hc;

    // Control fields
    localparam int CTRL_RANGE_LSB = 0;
    localparam int CTRL_RANGE_W = 3;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_TRIM_LSB = 8;
    localparam int TRIM_W = 8;
    localparam logic [2:0] RANGE_SW_RESET = 3'h0;
    localparam logic POL_RESET = 1'b0;
    localparam logic [7:0] TRIM_RESET = 8'hff;

    // Status fields
    localparam int STAT_LEAK_BIT = 0;
    localparam int STAT_BREAK_BIT = 1;
    localparam int STAT_CHECK_BIT = 2;
    localparam int STAT_TONE_BIT = 3;
    localparam int STAT_RANGE_LSB = 4;
    localparam int STAT_INDIC_BIT = 6;
    localparam int STAT_OUT_BIT = 7;

    localparam int SENSE_W = 8;

    typedef enum logic [1:0] {
        ST_POWER_UP,
        ST_MONITOR,
        ST_CHECK,
        ST_BROKEN
    } seq_state_t;

endpackage

// file: hw/level_sync.sv
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/10ps
module level_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// file: hw/square_div.sv
// Enabled square-wave divider; output low and phase reset while disabled
`timescale 1ns/10ps
module square_div #(
    parameter int unsigned HALF_CYC = 4,
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic en_i,
    output logic sq_o
);
    logic [W-1:0] cnt_q;
    wire half_done = (cnt_q == W'(HALF_CYC - 1));

    if (HALF_CYC < 1 || longint'(HALF_CYC) >= (longint'(1) << W)) begin : g_chk
        $error("square_div: HALF_CYC out of range");
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= '0;
            sq_o <= 1'b0;
        end else if (!en_i) begin
            cnt_q <= '0;
            sq_o <= 1'b0;
        end else if (half_done) begin
            cnt_q <= '0;
            sq_o <= !sq_o;
        end else begin
            cnt_q <= cnt_q + W'(1);
        end
    end
endmodule

// file: hw/leak_monitor.sv
// Leak and break monitor sequencer with Avalon-MM register slave
//
// What this block does
// [RQ1] Drive low-frequency AC tone while monitoring
// [RQ2] Compare returned level against set threshold
// [RQ3] Leak: steady indicator, output active
// [RQ4] First check by 2 s, then every 7 s
// [RQ5] 200 ms DC pulse, AC stopped meanwhile
// [RQ6] Pulse returned: band intact, resume monitoring
// [RQ7] No return: break, flash indicator, output active
// [RQ8] Check only across drive and sense pair
// [RQ9] Leak flagged: missing return still means break
// [RQ10] Break state suppresses all leak reporting
// [RQ11] Break latched until power is cycled
// [RQ12] Four ranges; trim sets threshold within
// [RQ13] Undefined switch setting selects largest range
// [RQ14] Polarity chooses output on or off
// [RQ15] Three switches select upper ranges; none lowest
// [RQ16] Polarity applies to leak and break alike
// [RQ17] Break reported within ten seconds
// [RQ18] Break flash toggles at about 1 Hz
// [RQ19] Leak samples taken only outside check window
`timescale 1ns/10ps
module leak_monitor
    import leak_monitor_pkg::*;
#(
    parameter int unsigned FIRST_CYC = 32'(FIRST_CHECK_CYC),
    parameter int unsigned PERIOD_CYC = 32'(CHECK_PERIOD_CYC),
    parameter int unsigned PULSE_CYC = 32'(CHECK_PULSE_CYC),
    parameter int unsigned TONE_HALF_CYC = 32'(AC_HALF_CYC),
    parameter int unsigned FLASH_CYC = 32'(FLASH_HALF_CYC),
    parameter int CNT_W = 32
) (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Avalon-MM slave
    input wire logic [3:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [3:0] byteenable_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // Band front end
    input wire logic [SENSE_W-1:0] sense_level_i,
    input wire logic dc_return_i,
    output logic ac_enable_o,
    output logic ac_tone_o,
    output logic dc_pulse_o,
    output logic [1:0] range_o,
    output logic [SENSE_W-1:0] threshold_o,
    // Indicator and switched output
    output logic indicator_o,
    output logic detect_out_o
);

    if (PULSE_CYC < 1 || PULSE_CYC >= PERIOD_CYC || FIRST_CYC < 1) begin : g_chk_time
        $error("leak_monitor: check timing parameters inconsistent");
    end
    if (longint'(PERIOD_CYC) >= (longint'(1) << CNT_W)) begin : g_chk_width
        $error("leak_monitor: CNT_W too small for check period");
    end
    // A break just after a check is reported at the end of the next window
    if (longint'(PERIOD_CYC) + longint'(PULSE_CYC) > longint'(DETECT_LIMIT_CYC)) begin : g_chk_limit
        $error("leak_monitor: check period exceeds break report limit");
    end

    // Switch decode: one switch per upper range, none for the lowest
    function automatic logic [1:0] range_decode(input logic [2:0] sw);
        case (sw)
            3'h0: range_decode = 2'h0; // RQ15
            3'h1: range_decode = 2'h1; // RQ15
            3'h2: range_decode = 2'h2; // RQ15
            3'h4: range_decode = 2'h3; // RQ15
            default: range_decode = RANGE_LARGEST; // RQ13
        endcase
    endfunction

    // Byte-lane merge for register writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        lane_merge = res;
    endfunction

    // Synchronised pin inputs
    logic [SENSE_W-1:0] sense_s;
    logic ret_s;

    level_sync #(
        .W(SENSE_W + 1)
    ) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .d_i({sense_level_i, dc_return_i}),
        .q_o({sense_s, ret_s})
    );

    // Control register state
    logic [2:0] range_sw_q;
    logic [2:0] range_sw_d;
    logic pol_q;
    logic pol_d;
    logic [TRIM_W-1:0] trim_q;
    logic [TRIM_W-1:0] trim_d;

    // Sequencer state
    seq_state_t state_q;
    seq_state_t state_d;
    logic [CNT_W-1:0] tmr_q;
    logic [CNT_W-1:0] tmr_d;
    logic seen_q;
    logic seen_d;
    logic leak_q;
    logic leak_d;
    logic brk_q;
    logic brk_d;
    logic [15:0] checks_q;
    logic [15:0] checks_d;

    // Bus answer state
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Front-end output flops
    logic ac_en_q;
    logic ac_en_d;
    logic dc_q;
    logic dc_d;
    logic [1:0] range_q;
    logic [SENSE_W-1:0] thr_q;
    logic [SENSE_W-1:0] thr_d;
    logic ind_q;
    logic ind_d;
    logic out_q;
    logic out_d;
    // Sense lags the pins by two flops, so the window echoes after it ends
    logic [1:0] quiet_q;
    logic [1:0] quiet_d;

    // Tone and flash generators
    logic tone;
    logic flash;

    square_div #(
        .HALF_CYC(TONE_HALF_CYC),
        .W(CNT_W)
    ) u_tone (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(ac_en_d),
        .sq_o(tone)
    );

    square_div #(
        .HALF_CYC(FLASH_CYC),
        .W(CNT_W)
    ) u_flash (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .en_i(brk_q),
        .sq_o(flash)
    );

    // Bus decode
    wire req = read_i | write_i;
    wire accept = req & wait_q;
    wire wr_take = write_i & ~wait_q;
    wire hit_ctrl = (address_i == REG_CTRL);
    wire hit_status = (address_i == REG_STATUS);
    wire hit_checks = (address_i == REG_CHECKS);
    wire hit_level = (address_i == REG_LEVEL);

    wire [31:0] ctrl_word = {16'h0000, trim_q, 4'h0, pol_q, range_sw_q};
    wire [31:0] ctrl_new = lane_merge(ctrl_word, writedata_i, byteenable_i);
    wire [31:0] status_word = {24'h000000, out_q, ind_q, range_q, ac_tone_o,
                               (state_q == ST_CHECK), brk_q, leak_q};
    wire [31:0] checks_word = {16'h0000, checks_q};
    wire [31:0] level_word = {8'h00, thr_q, 8'h00, sense_s};
    wire [31:0] read_word = hit_ctrl ? ctrl_word :
                            hit_status ? status_word :
                            hit_checks ? checks_word :
                            hit_level ? level_word : 32'h00000000;

    // One wait cycle, then answer; waitrequest idles high
    assign wait_d = ~accept;
    assign rdata_d = (accept & read_i) ? read_word : rdata_q;

    assign range_sw_d = (wr_take & hit_ctrl) ?
        ctrl_new[CTRL_RANGE_LSB +: CTRL_RANGE_W] : range_sw_q;
    assign pol_d = (wr_take & hit_ctrl) ? ctrl_new[CTRL_POL_BIT] : pol_q;
    assign trim_d = (wr_take & hit_ctrl) ? ctrl_new[CTRL_TRIM_LSB +: TRIM_W] : trim_q;

    // Higher trim means more sensitive, so a lower voltage trips it
    wire [1:0] range_sel = range_decode(range_sw_q); // RQ12
    assign thr_d = ~trim_q; // RQ12
    // Strict, so a dry band at full trim is no leak
    wire over_thr = (sense_s > thr_q); // RQ2

    // Sequencer timing
    wire tmr_end_first = (tmr_q == CNT_W'(FIRST_CYC - 1));
    wire tmr_end_pulse = (tmr_q == CNT_W'(PULSE_CYC - 1));
    wire tmr_end_gap = (tmr_q == CNT_W'(PERIOD_CYC - PULSE_CYC - 1));
    // Return seen at any point of the window counts, set wins at the end
    wire returned = seen_q | ret_s; // RQ8

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q + CNT_W'(1);
        seen_d = seen_q;
        brk_d = brk_q; // RQ11
        checks_d = checks_q;
        case (state_q)
            ST_POWER_UP: begin
                if (tmr_end_first) begin
                    state_d = ST_CHECK; // RQ4
                    tmr_d = '0;
                    seen_d = 1'b0;
                end
            end
            ST_MONITOR: begin
                if (tmr_end_gap) begin
                    state_d = ST_CHECK; // RQ4
                    tmr_d = '0;
                    seen_d = 1'b0;
                end
            end
            ST_CHECK: begin
                seen_d = returned; // RQ8
                if (tmr_end_pulse) begin // RQ5
                    tmr_d = '0;
                    checks_d = checks_q + 16'h0001;
                    if (returned) begin
                        state_d = ST_MONITOR; // RQ6
                    end else begin
                        // Holds whether or not a leak is flagged
                        state_d = ST_BROKEN; // RQ7 RQ9 RQ17
                        brk_d = 1'b1; // RQ7
                    end
                end
            end
            ST_BROKEN: begin
                // No exit: only power-on reset leaves this state
                tmr_d = tmr_q;
                brk_d = 1'b1; // RQ11
            end
            default: begin
                state_d = ST_BROKEN;
                brk_d = 1'b1;
            end
        endcase
    end

    // Leak decision only from samples outside the check window
    assign quiet_d = {quiet_q[0], ~dc_q}; // RQ19
    wire sampling = ((state_q == ST_MONITOR) || (state_q == ST_POWER_UP)) &&
                    (&quiet_q); // RQ19
    assign leak_d = brk_d ? 1'b0 : // RQ10
                    sampling ? over_thr : leak_q; // RQ2 RQ19

    // Excitation: AC in power-up and monitoring, DC pulse inside the window
    assign ac_en_d = (state_d == ST_MONITOR) || (state_d == ST_POWER_UP); // RQ1 RQ5
    assign dc_d = (state_d == ST_CHECK); // RQ5 RQ8

    // Steady for leak, flashing for break
    assign ind_d = brk_q ? flash : leak_q; // RQ3 RQ7 RQ18
    // Polarity low: output on at detection; high: output off
    assign out_d = (leak_q | brk_q) ^ pol_q; // RQ3 RQ14 RQ16

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
            range_sw_q <= RANGE_SW_RESET;
            pol_q <= POL_RESET;
            trim_q <= TRIM_RESET;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            range_sw_q <= range_sw_d;
            pol_q <= pol_d;
            trim_q <= trim_d;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_POWER_UP;
            tmr_q <= '0;
            seen_q <= 1'b0;
            leak_q <= 1'b0;
            brk_q <= 1'b0;
            checks_q <= 16'h0000;
            quiet_q <= '1;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
            seen_q <= seen_d;
            leak_q <= leak_d;
            brk_q <= brk_d;
            checks_q <= checks_d;
            quiet_q <= quiet_d;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ac_en_q <= 1'b0;
            dc_q <= 1'b0;
            range_q <= RANGE_LARGEST;
            thr_q <= ~TRIM_RESET;
            ind_q <= 1'b0;
            out_q <= POL_RESET;
        end else begin
            ac_en_q <= ac_en_d;
            dc_q <= dc_d;
            range_q <= range_sel;
            thr_q <= thr_d;
            ind_q <= ind_d;
            out_q <= out_d;
        end
    end

    assign waitrequest_o = wait_q;
    assign readdata_o = rdata_q;
    assign ac_enable_o = ac_en_q;
    assign ac_tone_o = tone; // RQ1
    assign dc_pulse_o = dc_q;
    assign range_o = range_q;
    assign threshold_o = thr_q;
    assign indicator_o = ind_q;
    assign detect_out_o = out_q;

endmodule

// file: verif/band_model.sv
// Behavioural sensing band closed by an end terminator
`timescale 1ns/10ps
module band_model
    import leak_monitor_pkg::*;
(
    // From the monitor
    input wire logic dc_pulse_i,
    // Band condition set by the bench
    input wire logic intact_i,
    input wire logic [SENSE_W-1:0] wet_level_i,
    // Back to the monitor
    output logic dc_return_o,
    output logic [SENSE_W-1:0] sense_level_o
);
    // Pulse also comes back through liquid, even past a cut
    assign dc_return_o = dc_pulse_i & (intact_i | (wet_level_i != 8'h00));
    // Returned pulse lands on sense at full scale
    assign sense_level_o = dc_return_o ? 8'hff : wet_level_i;
endmodule

// file: verif/leak_monitor_properties.sv
// Checker of bus wait, check sequencing and indicator timing
`timescale 1ns/10ps
module leak_monitor_properties
    import leak_monitor_pkg::*;
#(
    parameter int unsigned FIRST_CYC = 50,
    parameter int unsigned PERIOD_CYC = 200,
    parameter int unsigned PULSE_CYC = 20,
    parameter int unsigned FLASH_CYC = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Bus handshake
    input wire logic read_i,
    input wire logic write_i,
    input wire logic waitrequest_o,
    // Band and indication
    input wire logic [SENSE_W-1:0] sense_level_i,
    input wire logic dc_return_i,
    input wire logic ac_enable_o,
    input wire logic ac_tone_o,
    input wire logic dc_pulse_o,
    input wire logic [SENSE_W-1:0] threshold_o,
    input wire logic indicator_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    int win_q, gap_q, age_q, hold_q, brk_age_q;
    logic seen_q, ret_q, brk_q, pulse_q, ind_q;
    // Break seen from the ports alone: a window with no return
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            {win_q, gap_q, age_q, hold_q, brk_age_q} <= '0;
            {seen_q, ret_q, brk_q, pulse_q, ind_q} <= '0;
        end else begin
            pulse_q <= dc_pulse_o;
            ind_q <= indicator_o;
            win_q <= dc_pulse_o ? win_q + 1 : 0;
            gap_q <= (dc_pulse_o && !pulse_q) ? 1 : gap_q + 1;
            age_q <= age_q + 1;
            seen_q <= seen_q | dc_pulse_o;
            hold_q <= (indicator_o != ind_q) ? 1 : hold_q + 1;
            ret_q <= dc_pulse_o & (ret_q | dc_return_i);
            brk_q <= brk_q | (pulse_q & !dc_pulse_o & !ret_q);
            brk_age_q <= brk_q ? brk_age_q + 1 : 0;
        end
    end
    property p_wait_one;
        (read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o;
    endproperty
    property p_wait_idle;
        !(read_i || write_i) && waitrequest_o |=> waitrequest_o;
    endproperty
    property p_win_len;
        $fell(dc_pulse_o) |-> win_q == PULSE_CYC;
    endproperty
    property p_win_ac;
        dc_pulse_o |-> !ac_enable_o && !ac_tone_o;
    endproperty
    property p_tone_gate;
        !ac_enable_o |-> !ac_tone_o;
    endproperty
    property p_first;
        $rose(dc_pulse_o) && !seen_q |-> age_q + 2 >= FIRST_CYC && age_q <= FIRST_CYC + 2;
    endproperty
    property p_period;
        $rose(dc_pulse_o) && seen_q |-> gap_q == PERIOD_CYC;
    endproperty
    property p_leak;
        ($stable(sense_level_i) && $stable(threshold_o) && !dc_pulse_o && !brk_q)[*8]
            |-> indicator_o == (sense_level_i > threshold_o);
    endproperty
    property p_quiet;
        $fell(dc_pulse_o) && !indicator_o && sense_level_i <= threshold_o
            |=> !indicator_o [*4];
    endproperty
    property p_flash;
        brk_age_q > 2 * FLASH_CYC + 8 |-> hold_q <= FLASH_CYC;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
    a_wait_idle: assert property (p_wait_idle) else $error("wait dropped unasked");
    a_win_len: assert property (p_win_len) else $error("window length");
    a_win_ac: assert property (p_win_ac) else $error("tone in window");
    a_tone_gate: assert property (p_tone_gate) else $error("tone while off");
    a_first: assert property (p_first) else $error("first check time");
    a_period: assert property (p_period) else $error("check period");
    a_leak: assert property (p_leak) else $error("leak decision");
    a_flash: assert property (p_flash) else $error("break flash");
    a_quiet: assert property (p_quiet) else $error("leak from window echo");
    c_window: cover property ($rose(dc_pulse_o));
    c_break: cover property (brk_q && $changed(indicator_o));
    c_write: cover property (write_i && !waitrequest_o);
endmodule
bind leak_monitor leak_monitor_properties #(.FIRST_CYC(FIRST_CYC), .PERIOD_CYC(PERIOD_CYC),
    .PULSE_CYC(PULSE_CYC), .FLASH_CYC(FLASH_CYC)) chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .read_i(read_i), .write_i(write_i), .waitrequest_o(waitrequest_o),
    .sense_level_i(sense_level_i), .dc_return_i(dc_return_i), .ac_enable_o(ac_enable_o),
    .ac_tone_o(ac_tone_o), .dc_pulse_o(dc_pulse_o), .threshold_o(threshold_o),
    .indicator_o(indicator_o));

// file: verif/tb_top.sv
// Self-checking bench of the leak monitor with a band model
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("Error %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_top
    import leak_monitor_pkg::*;
;
    localparam int FIRST = 50;
    localparam int PERIOD = 200;
    localparam int PULSE = 20;
    localparam int FLASH = 8;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest, dc_return, ac_en, tone, pulse, ind, dout;
    logic [7:0] sense, thr;
    logic [1:0] range;
    logic intact = 1'b1;
    logic [7:0] wet = 8'h00;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [1:0] exp_rng [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

    leak_monitor #(.FIRST_CYC(FIRST), .PERIOD_CYC(PERIOD), .PULSE_CYC(PULSE),
        .TONE_HALF_CYC(5), .FLASH_CYC(FLASH)) dut_u (
        .clk_i(clk), .nrst_i(nrst), .address_i(address), .read_i(read), .write_i(write),
        .byteenable_i(4'hf), .writedata_i(writedata), .readdata_o(readdata),
        .waitrequest_o(waitrequest), .sense_level_i(sense), .dc_return_i(dc_return),
        .ac_enable_o(ac_en), .ac_tone_o(tone), .dc_pulse_o(pulse), .range_o(range),
        .threshold_o(thr), .indicator_o(ind), .detect_out_o(dout));
    band_model band_u (.dc_pulse_i(pulse), .intact_i(intact), .wet_level_i(wet),
        .dc_return_o(dc_return), .sense_level_o(sense));

    initial forever #5 clk = ~clk;

    task automatic give_verdict();
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Starts one edge late so a released strobe never rises in the same step
    task automatic bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr_en;
        read <= !wr_en;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic band(input logic i, input logic [7:0] w);
        @(posedge clk);
        intact <= i;
        wet <= w;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_lvl(input logic lvl, inout int n);
        while (pulse !== lvl) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Leak is frozen in the window, so judge it well after one
    task automatic after_win();
        int n;
        n = 0;
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        settle(8);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        logic [31:0] q;
        int n;
        logic prev;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        n = 0;
        wait_lvl(1'b1, n);
        `CHK(n >= FIRST - 2 && n <= FIRST + 2, 1'b1)
        `CHK(ac_en, 1'b0)
        n = 0;
        wait_lvl(1'b0, n);
        `CHK(n, PULSE)
        wait_lvl(1'b1, n);
        `CHK(n, PERIOD)
        wait_lvl(1'b0, n);
        rd(REG_CTRL, q);
        `CHK(q, 32'h0000ff00)
        rd(4'h2, q);
        `CHK(q, 32'h0)
        for (int c = 0; c < 8; c++) begin
            wr(REG_CTRL, 32'h8000 | c);
            settle(2);
            `CHK(range, exp_rng[c])
        end
        wr(REG_CTRL, 32'h8000);
        wr(REG_STATUS, 32'hffffffff);
        settle(2);
        `CHK(thr, 8'h7f)
        `CHK(range, 2'h0)
        band(1'b1, 8'hc0);
        after_win();
        `CHK(ind, 1'b1)
        `CHK(dout, 1'b1)
        wr(REG_CTRL, 32'h8008);
        settle(3);
        `CHK(dout, 1'b0)
        band(1'b1, 8'h10);
        n = 0;
        wait_lvl(1'b1, n);
        settle(PULSE - 2);
        `CHK(ind, 1'b0)
        after_win();
        rd(REG_STATUS, q);
        `CHK(q[STAT_BREAK_BIT], 1'b0)
        `CHK(dout, 1'b1)
        wr(REG_CTRL, 32'h8000);
        band(1'b0, 8'hc0);
        after_win();
        `CHK(ind, 1'b1)
        band(1'b0, 8'h00);
        after_win();
        rd(REG_STATUS, q);
        `CHK({q[STAT_BREAK_BIT], q[STAT_LEAK_BIT]}, 2'b10)
        `CHK(dout, 1'b1)
        n = 0;
        prev = ind;
        repeat (4 * FLASH) begin
            @(posedge clk);
            n += int'(ind !== prev);
            prev = ind;
        end
        `CHK(n, 4)
        band(1'b1, 8'hc0);
        settle(PERIOD + 20);
        rd(REG_STATUS, q);
        `CHK({q[STAT_BREAK_BIT], q[STAT_LEAK_BIT]}, 2'b10)
        rd(REG_CHECKS, q);
        `CHK(q, 32'h00000006)
        rd(REG_LEVEL, q);
        `CHK(q, 32'h007f00c0)
        wr(REG_CTRL, 32'h8008);
        settle(3);
        `CHK(dout, 1'b0)
        band(1'b1, 8'h00);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(REG_STATUS, q);
        `CHK(q[STAT_BREAK_BIT], 1'b0)
        give_verdict();
    end
endmodule
